// *** sgcfg_fifo.sv ***
// sgcfg_fifo: synchronous fifo with valid/ready on both sides
// assumes: one clock, active-low asynchronous reset
`timescale 1ns/1ns
module sgcfg_fifo
   import sgcfg_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;

   always_comb begin
      push  = in_valid && in_ready;
      pop   = out_valid && out_ready;
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_b)
      cnt_q <= DEPTH[AW:0]) else $error("fifo count above depth");
endmodule // sgcfg_fifo

// *** sgcfg_lenq.sv ***
// sgcfg_lenq: catches the receive length from the status stream
// assumes: status beats are synchronous to clk; last beat marks packet end
`timescale 1ns/1ns
module sgcfg_lenq
   import sgcfg_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          enable,
   input  wire logic [STATUS_STREAM_WIDTH-1:0] sts_tdata,
   input  wire logic                          sts_tvalid,
   input  wire logic                          sts_tlast,
   input  wire logic                          take,
   output logic                               len_valid,
   output logic [LENGTH_FIELD_WIDTH-1:0]      len_value
);
   logic                          valid_q, valid_d;
   logic [LENGTH_FIELD_WIDTH-1:0] len_q, len_d;

   always_comb begin
      valid_d = valid_q;
      len_d   = len_q;
      if (take) begin
         valid_d = 1'b0;
      end
      // set wins over the consuming clear
      if (enable && sts_tvalid && sts_tlast) begin // RULE19
         valid_d = 1'b1;
         len_d   = sts_tdata[LENGTH_FIELD_WIDTH-1:0]; // RULE18
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         valid_q <= 1'b0;
         len_q   <= '0;
      end else begin
         valid_q <= valid_d;
         len_q   <= len_d;
      end
   end

   assign len_valid = valid_q;
   assign len_value = len_q;
endmodule // sgcfg_lenq

// *** sgcfg_mem_model.sv ***
// sgcfg_mem_model: behavioural descriptor memory on the far side of the
// descriptor master; answers fetches with eight words and acks updates
// assumes: requests are levels held until ack; lat sets the answer delay
`timescale 1ns/1ns
module sgcfg_mem_model
   import sgcfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [31:0] desc_rd_addr,
   input  wire logic        desc_rd_req,
   output logic             desc_rd_ack,
   output logic      [31:0] desc_rd_data,
   output logic             desc_rd_dvalid,
   input  wire logic        desc_wr_req,
   output logic             desc_wr_ack,
   input  wire logic [3:0]  lat
);
   logic [31:0] base;
   int          i;

   initial begin
      desc_rd_ack    = 1'b0;
      desc_rd_data   = 32'h0000_0000;
      desc_rd_dvalid = 1'b0;
      desc_wr_ack    = 1'b0;
   end

   // word 0 links to the next slot, word 6 is the control word
   always begin
      @(posedge clk);
      if (desc_rd_req === 1'b1) begin
         base = desc_rd_addr;
         repeat (lat) @(posedge clk);
         desc_rd_ack <= 1'b1;
         @(posedge clk);
         desc_rd_ack <= 1'b0;
         for (i = 0; i < DESC_WORDS; i++) begin
            desc_rd_dvalid <= 1'b1;
            desc_rd_data   <= (i == 0) ? base + 32'h0000_0040 :
                              (i == 6) ? {16'hA5C3, base[15:0]} : base + i;
            @(posedge clk);
         end
         desc_rd_dvalid <= 1'b0;
         // released data line does not keep its last value
         desc_rd_data   <= ~desc_rd_data;
      end else if (desc_wr_req === 1'b1) begin
         repeat (lat) @(posedge clk);
         desc_wr_ack <= 1'b1;
         @(posedge clk);
         desc_wr_ack <= 1'b0;
      end
   end
endmodule // sgcfg_mem_model

// *** sgcfg_pkg.sv ***
// sgcfg_pkg: constants, modes and states of the dma configuration block
// assumes: included first by every design file of the block
package sgcfg_pkg;
   localparam int DESC_BUS_DATA_WIDTH  = 32;
   localparam int DESC_BUS_ADDR_WIDTH  = 32;
   localparam int STATUS_STREAM_WIDTH  = 32;
   localparam int CONTROL_STREAM_WIDTH = 32;
   localparam int LENGTH_WIDTH_MIN     = 8;
   localparam int LENGTH_WIDTH_MAX     = 23;
   localparam int LENGTH_FIELD_WIDTH   = 14;
   localparam int DATA_WIDTH           = 32;
   localparam int FIFO_DEPTH           = 16;
   localparam int DESC_QUEUE_DEPTH     = 4;
   localparam int DESC_QUEUE_IDX_W     = 2;
   localparam int DESC_QUEUE_CNT_W     = 3;
   localparam int DESC_WORDS           = 8;
   localparam int DESC_WORD_IDX_W      = 3;
   localparam int DESC_OFS_NEXT        = 0;
   localparam int DESC_OFS_BUFFER      = 2;
   localparam int DESC_OFS_CONTROL     = 6;
   localparam int DESC_OFS_STATUS      = 7;
   localparam int SIMPLE_MODE          = 0;
   localparam int SG_MODE              = 1;
   localparam logic RST_SG_OPTION      = 1'b1;
   localparam logic RST_QUEUE_OPTION   = 1'b0;
   localparam logic RST_SIDEBAND       = 1'b1;
   localparam logic RST_STS_LENGTH     = 1'b1;
   localparam logic RST_ASYNC_CLOCK    = 1'b0;
   localparam int GAP_QUEUED_CYCLES    = 1;
   localparam logic [DESC_BUS_DATA_WIDTH-1:0] DESC_CMPLT_BIT =
      32'h8000_0000;
   localparam logic [DESC_BUS_DATA_WIDTH-1:0] DESC_SHORT_BIT =
      32'h4000_0000;

   typedef enum logic [2:0] {
      SGCFG_IDLE  = 3'b000,
      SGCFG_FETCH = 3'b001,
      SGCFG_XFER  = 3'b010,
      SGCFG_UPD   = 3'b011,
      SGCFG_WAIT  = 3'b100
   } sgcfg_state_t;
endpackage

// *** sgcfg_top.sv ***
// Operation
// RULE1: descriptor master data bus is 32 bits for reads and writes.
// RULE2: descriptor master address bus is 32 bits for reads and writes.
// RULE3: option 0 selects simple mode, 1 scatter/gather; default 1.
// RULE4: without scatter/gather, fetch outputs stay low and inputs ignored.
// RULE5: with queuing, descriptors prefetched; gap about one clock. Code re-reads cur_q in transfer and discards it; next_q fetched after update.
// RULE6: without queuing, fetch, transfer, update, then next fetch.
// RULE7: without queuing, idle cycles may appear between or inside packets.
// RULE8: queue, sideband and length options act only in scatter/gather mode.
// RULE9: sideband emits read-channel control words, takes write status words.
// RULE10: per-packet metadata rides sideband streams, not primary data.
// RULE11: status input stream words are 32 bits.
// RULE12: control output stream words are 32 bits.
// RULE13: last status word captured as receive length ahead of data.
// RULE14: data mover commanded with exactly the receive byte count.
// RULE15: fewer bytes than commanded is a shortfall, handled cleanly. Code compares the beat count got_q + 1 with the byte count bytes_q.
// RULE16: without length option, store-and-forward before memory writes.
// RULE17: clock frequency settings only matter with async option set.
// RULE18: receive length sits in low length-width bits of last status word.
// RULE19: last status word is the beat flagged with packet end.
// sgcfg_top: descriptor sequencer, sideband streams and write length path
// assumes: one clock; memory answers descriptor reads on desc_rd_* pins
`timescale 1ns/1ns
module sgcfg_top
   import sgcfg_pkg::*;
(
   input  wire logic                            clk,
   input  wire logic                            rst_b,
   input  wire logic                            scatter_gather_option,
   input  wire logic                            descriptor_queue_option,
   input  wire logic                            sideband_stream_option,
   input  wire logic                            status_length_option,
   input  wire logic                            async_clock_option,
   input  wire logic                            run,
   input  wire logic [DESC_BUS_ADDR_WIDTH-1:0]  first_desc_addr,
   output logic      [DESC_BUS_ADDR_WIDTH-1:0]  desc_rd_addr,
   output logic                                 desc_rd_req,
   input  wire logic                            desc_rd_ack,
   input  wire logic [DESC_BUS_DATA_WIDTH-1:0]  desc_rd_data,
   input  wire logic                            desc_rd_dvalid,
   output logic      [DESC_BUS_ADDR_WIDTH-1:0]  desc_wr_addr,
   output logic      [DESC_BUS_DATA_WIDTH-1:0]  desc_wr_data,
   output logic                                 desc_wr_req,
   input  wire logic                            desc_wr_ack,
   output logic      [CONTROL_STREAM_WIDTH-1:0] ctl_tdata,
   output logic                                 ctl_tvalid,
   output logic                                 ctl_tlast,
   input  wire logic                            ctl_tready,
   input  wire logic [STATUS_STREAM_WIDTH-1:0]  sts_tdata,
   input  wire logic                            sts_tvalid,
   input  wire logic                            sts_tlast,
   output logic                                 sts_tready,
   input  wire logic [DATA_WIDTH-1:0]           wr_tdata,
   input  wire logic                            wr_tvalid,
   input  wire logic                            wr_tlast,
   output logic                                 wr_tready,
   output logic      [DATA_WIDTH-1:0]           mem_wdata,
   output logic                                 mem_wvalid,
   input  wire logic                            mem_wready,
   output logic      [LENGTH_FIELD_WIDTH-1:0]   mover_bytes,
   output logic                                 mover_cmd,
   output logic                                 shortfall,
   output logic                                 sg_active,
   output logic                                 cdc_in_use
);
   logic                                 sg_on, q_on, sb_on, len_on;
   sgcfg_state_t                         st_q, st_d;
   logic [DESC_BUS_ADDR_WIDTH-1:0]       cur_q, cur_d;
   logic [DESC_BUS_ADDR_WIDTH-1:0]       next_q, next_d;
   logic [DESC_WORD_IDX_W-1:0]           word_q, word_d;
   logic [DESC_BUS_DATA_WIDTH-1:0]       ctlw_q, ctlw_d;
   logic                                 rd_req_q, rd_req_d;
   logic                                 wr_req_q, wr_req_d;
   logic [DESC_QUEUE_CNT_W-1:0]          qcnt_q, qcnt_d;
   logic [DESC_BUS_DATA_WIDTH-1:0]       side_q, side_d;
   logic                                 ctlv_q, ctlv_d;
   logic [LENGTH_FIELD_WIDTH-1:0]        bytes_q, bytes_d, got_q, got_d;
   logic                                 cmd_q, cmd_d, short_q, short_d;
   logic                                 pkt_done_q, pkt_done_d;
   logic                                 fifo_out_v, fifo_out_r, fifo_in_r;
   logic [DATA_WIDTH-1:0]                fifo_out_d;
   logic [$clog2(FIFO_DEPTH):0]          fifo_lvl;
   logic                                 len_v, len_take;
   logic [LENGTH_FIELD_WIDTH-1:0]        len_val;
   logic                                 wbeat;

   // queue, sideband and length options are qualified by scatter/gather
   assign sg_on  = scatter_gather_option == 1'(SG_MODE); // RULE3
   assign q_on   = sg_on && descriptor_queue_option;      // RULE8
   assign sb_on  = sg_on && sideband_stream_option;       // RULE8
   assign len_on = sb_on && status_length_option;         // RULE8

   sgcfg_lenq u_lenq (
      .clk        (clk),
      .rst_b      (rst_b),
      .enable     (len_on),
      .sts_tdata  (sts_tdata),
      .sts_tvalid (sts_tvalid),
      .sts_tlast  (sts_tlast),
      .take       (len_take),
      .len_valid  (len_v),
      .len_value  (len_val)
   );

   sgcfg_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_data   (wr_tdata),
      .in_valid  (wr_tvalid),
      .in_ready  (fifo_in_r),
      .out_data  (fifo_out_d),
      .out_valid (fifo_out_v),
      .out_ready (fifo_out_r),
      .level     (fifo_lvl)
   );

   assign wbeat = wr_tvalid && fifo_in_r;

   // descriptor sequencer
   always_comb begin
      st_d     = st_q;
      cur_d    = cur_q;
      next_d   = next_q;
      word_d   = word_q;
      ctlw_d   = ctlw_q;
      rd_req_d = rd_req_q;
      wr_req_d = wr_req_q;
      qcnt_d   = qcnt_q;
      unique case (st_q)
         SGCFG_IDLE: begin
            if (run && sg_on) begin
               cur_d    = first_desc_addr;
               word_d   = '0;
               rd_req_d = 1'b1;
               st_d     = SGCFG_FETCH;
            end
         end
         SGCFG_FETCH: begin
            if (desc_rd_ack) begin
               rd_req_d = 1'b0;
            end
            if (desc_rd_dvalid) begin
               if (word_q == DESC_WORD_IDX_W'(DESC_OFS_NEXT)) begin
                  next_d = desc_rd_data;
               end
               if (word_q == DESC_WORD_IDX_W'(DESC_OFS_CONTROL)) begin
                  ctlw_d = desc_rd_data;
               end
               word_d = word_q + 1'b1;
               if (word_q == DESC_WORD_IDX_W'(DESC_WORDS - 1)) begin
                  st_d = SGCFG_XFER;
                  if (q_on && qcnt_q < DESC_QUEUE_CNT_W'(DESC_QUEUE_DEPTH))
                  begin
                     qcnt_d = qcnt_q + 1'b1; // RULE5
                  end
               end
            end
         end
         SGCFG_XFER: begin
            if (pkt_done_q || !run) begin
               wr_req_d = 1'b1;
               st_d     = SGCFG_UPD;
            end else if (q_on && qcnt_q != '0 && !rd_req_q) begin
               // raise a read request at cur_q while this one transfers
               rd_req_d = 1'b1; // RULE5
            end
         end
         SGCFG_UPD: begin
            if (desc_wr_ack) begin
               wr_req_d = 1'b0;
               if (qcnt_q != '0) begin
                  qcnt_d = qcnt_q - 1'b1;
               end
               st_d = SGCFG_WAIT; // RULE7
            end
         end
         SGCFG_WAIT: begin
            // next fetch only after the update is written back
            cur_d  = next_q; // RULE6
            word_d = '0;
            if (run) begin
               rd_req_d = 1'b1; // RULE6
               st_d     = SGCFG_FETCH;
            end else begin
               st_d = SGCFG_IDLE;
            end
         end
         default: st_d = SGCFG_IDLE;
      endcase
      if (!sg_on) begin
         st_d     = SGCFG_IDLE; // RULE4
         rd_req_d = 1'b0;
         wr_req_d = 1'b0;
         qcnt_d   = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q     <= SGCFG_IDLE;
         cur_q    <= '0;
         next_q   <= '0;
         word_q   <= '0;
         ctlw_q   <= '0;
         rd_req_q <= 1'b0;
         wr_req_q <= 1'b0;
         qcnt_q   <= '0;
      end else begin
         st_q     <= st_d;
         cur_q    <= cur_d;
         next_q   <= next_d;
         word_q   <= word_d;
         ctlw_q   <= ctlw_d;
         rd_req_q <= rd_req_d;
         wr_req_q <= wr_req_d;
         qcnt_q   <= qcnt_d;
      end
   end

   // sideband control word out, write length path
   always_comb begin
      side_d     = side_q;
      ctlv_d     = ctlv_q;
      bytes_d    = bytes_q;
      got_d      = got_q;
      cmd_d      = 1'b0;
      short_d    = short_q;
      pkt_done_d = 1'b0;
      len_take   = 1'b0;
      if (ctlv_q && ctl_tready) begin
         ctlv_d = 1'b0;
      end
      if (sb_on && st_q == SGCFG_FETCH && desc_rd_dvalid &&
          word_q == DESC_WORD_IDX_W'(DESC_OFS_CONTROL)) begin
         side_d = desc_rd_data; // RULE9 RULE10 RULE12
         ctlv_d = 1'b1;
      end
      if (len_on && len_v && st_q == SGCFG_XFER && got_q == '0) begin
         bytes_d  = len_val; // RULE13 RULE14
         cmd_d    = 1'b1;
         len_take = 1'b1;
      end else if (!len_on && st_q == SGCFG_XFER && wr_tlast && wbeat) begin
         // whole packet buffered before the mover is commanded
         bytes_d = LENGTH_FIELD_WIDTH'(got_q + 1'b1); // RULE16
         cmd_d   = 1'b1;
      end
      if (wbeat) begin
         got_d = wr_tlast ? '0 : LENGTH_FIELD_WIDTH'(got_q + 1'b1);
         if (wr_tlast) begin
            pkt_done_d = 1'b1;
            short_d = len_on &&
               (LENGTH_FIELD_WIDTH'(got_q + 1'b1) < bytes_q); // RULE15
         end
      end
      if (!sg_on) begin
         ctlv_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         side_q     <= '0;
         ctlv_q     <= 1'b0;
         bytes_q    <= '0;
         got_q      <= '0;
         cmd_q      <= 1'b0;
         short_q    <= 1'b0;
         pkt_done_q <= 1'b0;
      end else begin
         side_q     <= side_d;
         ctlv_q     <= ctlv_d;
         bytes_q    <= bytes_d;
         got_q      <= got_d;
         cmd_q      <= cmd_d;
         short_q    <= short_d;
         pkt_done_q <= pkt_done_d;
      end
   end

   // store-and-forward holds data while a packet is only partly in
   assign fifo_out_r = mem_wready && (len_on || got_q == '0); // RULE16

   // descriptor bus outputs, addresses and data low while scatter/gather is off, requests one cycle later
   assign desc_rd_addr = sg_on ? cur_q : '0;          // RULE2 RULE4
   assign desc_rd_req  = rd_req_q;                     // RULE4
   assign desc_wr_addr = sg_on ?
      cur_q + DESC_BUS_ADDR_WIDTH'(DESC_OFS_STATUS * 4) : '0; // RULE2
   assign desc_wr_data = sg_on ?
      (DESC_CMPLT_BIT | (short_q ? DESC_SHORT_BIT : '0) |
       DESC_BUS_DATA_WIDTH'(bytes_q)) : '0;            // RULE1 RULE4
   assign desc_wr_req  = wr_req_q;
   assign ctl_tdata    = side_q;
   assign ctl_tvalid   = ctlv_q;
   assign ctl_tlast    = ctlv_q;
   assign sts_tready   = sb_on;                        // RULE11
   assign wr_tready    = fifo_in_r;
   assign mem_wdata    = fifo_out_d;
   assign mem_wvalid   = fifo_out_v;
   assign mover_bytes  = bytes_q;
   assign mover_cmd    = cmd_q;
   assign shortfall    = short_q;
   assign sg_active    = st_q != SGCFG_IDLE;
   assign cdc_in_use   = async_clock_option;           // RULE17

   a_sg_off_quiet: assert property (@(posedge clk) disable iff (!rst_b)
      !sg_on |=> !desc_rd_req && !desc_wr_req) // RULE4
      else $error("descriptor request while scatter/gather off");
   sequence s_upd_acked;
      !q_on && st_q == SGCFG_UPD && desc_wr_ack && run && sg_on;
   endsequence
   a_fetch_after_upd: assert property (@(posedge clk) disable iff (!rst_b)
      s_upd_acked |=> ##1 rd_req_q) // RULE6
      else $error("next fetch not issued after update");
   a_len_cmd: assert property (@(posedge clk) disable iff (!rst_b)
      (len_on && len_v && st_q == SGCFG_XFER && got_q == '0)
      |=> cmd_q && mover_bytes == $past(len_val)) // RULE14
      else $error("mover byte count differs from receive length");
   a_ctl_word: assert property (@(posedge clk) disable iff (!rst_b)
      (sb_on && st_q == SGCFG_FETCH && desc_rd_dvalid &&
       word_q == DESC_WORD_IDX_W'(DESC_OFS_CONTROL))
      |=> ctl_tvalid && ctl_tdata == $past(desc_rd_data)) // RULE9
      else $error("control word not sent");
   a_ctl_hold: assert property (@(posedge clk) disable iff (!rst_b)
      ctl_tvalid && !ctl_tready && sg_on |=> ctl_tvalid) // RULE12
      else $error("control word dropped before accept");
   a_no_sideband: assert property (@(posedge clk) disable iff (!rst_b)
      !sb_on |-> !sts_tready) // RULE8
      else $error("status stream ready without sideband");
endmodule // sgcfg_top

// *** tb_top.sv ***
// tb_top: drives options, status and data streams; memory model answers
// assumes: inputs change on the falling edge, fifo depth FIFO_DEPTH
`timescale 1ns/1ns
module tb_top
   import sgcfg_pkg::*;
;
   logic        clk, rst_b, sg, dq, sb, sl, ac, run;
   logic [31:0] first_addr, rd_addr, rd_data, wr_addr, wr_data, ctl_data;
   logic        rd_req, rd_ack, rd_dv, wr_req, wr_ack, ctl_v, ctl_l, ctl_r;
   logic [31:0] sts_d, w_d, m_d;
   logic        sts_v, sts_l, sts_r, w_v, w_l, w_r, m_v, m_r;
   logic [13:0] mbytes;
   logic        mcmd, short, sg_act, cdc;
   logic [3:0]  lat;
   int          n_mismatch, check_count, k, n, d;

   sgcfg_top i_dut (.clk(clk), .rst_b(rst_b), .scatter_gather_option(sg),
      .descriptor_queue_option(dq), .sideband_stream_option(sb),
      .status_length_option(sl), .async_clock_option(ac), .run(run),
      .first_desc_addr(first_addr), .desc_rd_addr(rd_addr),
      .desc_rd_req(rd_req), .desc_rd_ack(rd_ack), .desc_rd_data(rd_data),
      .desc_rd_dvalid(rd_dv), .desc_wr_addr(wr_addr), .desc_wr_data(wr_data),
      .desc_wr_req(wr_req), .desc_wr_ack(wr_ack), .ctl_tdata(ctl_data),
      .ctl_tvalid(ctl_v), .ctl_tlast(ctl_l), .ctl_tready(ctl_r),
      .sts_tdata(sts_d), .sts_tvalid(sts_v), .sts_tlast(sts_l),
      .sts_tready(sts_r), .wr_tdata(w_d), .wr_tvalid(w_v), .wr_tlast(w_l),
      .wr_tready(w_r), .mem_wdata(m_d), .mem_wvalid(m_v), .mem_wready(m_r),
      .mover_bytes(mbytes), .mover_cmd(mcmd), .shortfall(short),
      .sg_active(sg_act), .cdc_in_use(cdc));

   sgcfg_mem_model i_mem (.clk(clk), .desc_rd_addr(rd_addr),
      .desc_rd_req(rd_req), .desc_rd_ack(rd_ack), .desc_rd_data(rd_data),
      .desc_rd_dvalid(rd_dv), .desc_wr_req(wr_req), .desc_wr_ack(wr_ack),
      .lat(lat));

   always #20 clk = ~clk;

   task automatic chk(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one status beat, held until the design takes it
   task automatic send_sts(input logic [31:0] data, input logic last);
      @(negedge clk);
      sts_v = 1'b1;
      sts_d = data;
      sts_l = last;
      for (k = 0; k < 100; k++) begin
         @(posedge clk);
         if (sts_r === 1'b1) break;
      end
      @(negedge clk);
      sts_v = 1'b0;
      sts_d = ~data;
   endtask

   // drain the fifo and compare word order
   task automatic drain(input int cnt);
      @(negedge clk);
      m_r = 1'b1;
      for (k = 0; k < 200 && d < cnt; k++) begin
         @(posedge clk);
         if (m_v === 1'b1) begin
            chk("mem_wdata", m_d, 32'h0000_0D00 + d);
            d++;
         end
      end
      // stall the memory again so later words wait in the fifo
      @(negedge clk);
      m_r = 1'b0;
      chk("drain_count", d, cnt);
   endtask

   initial begin
      #800000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      clk = 1'b0; rst_b = 1'b0; sg = 1'b0; dq = 1'b1; sb = 1'b1; sl = 1'b1;
      ac = 1'b0; run = 1'b0; first_addr = 32'h0000_1000; ctl_r = 1'b0;
      sts_d = 32'h0000_0000; sts_v = 1'b0; sts_l = 1'b0; w_d = 32'h0;
      w_v = 1'b0; w_l = 1'b0; m_r = 1'b0; lat = 4'h0;
      n_mismatch = 0; check_count = 0; d = 0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      ac = 1'b1;
      #1 chk("cdc_in_use", cdc, 1'b1);
      @(negedge clk);
      ac = 1'b0;
      run = 1'b1;
      repeat (20) begin
         @(negedge clk);
         chk("sg_off_out", {rd_req, wr_req, ctl_v, sg_act, mcmd}, 0);
         chk("sg_off_addr", rd_addr | wr_addr | ctl_data, 0);
         chk("sg_off_sts_ready", sts_r, 1'b0);
      end
      run = 1'b0;
      dq = 1'b0;
      sg = 1'b1;
      @(negedge clk);
      run = 1'b1;
      for (k = 0; k < 50 && rd_req !== 1'b1; k++) @(negedge clk);
      chk("fetch_addr", rd_addr, 32'h0000_1000);
      for (k = 0; k < 100 && ctl_v !== 1'b1; k++) @(negedge clk);
      repeat (3) @(negedge clk);
      chk("ctl_hold", ctl_v, 1'b1);
      chk("ctl_word", ctl_data, 32'hA5C3_1000);
      chk("ctl_last", ctl_l, 1'b1);
      chk("sts_ready", sts_r, 1'b1);
      ctl_r = 1'b1;
      send_sts(32'h1234_4321, 1'b0);
      chk("no_cmd_early", mcmd, 1'b0);
      send_sts(32'hABCC_0100, 1'b1);
      for (k = 0; k < 3 && mcmd !== 1'b1; k++) @(negedge clk);
      chk("mover_cmd", mcmd, 1'b1);
      chk("mover_bytes", mbytes, 14'h0100);
      // fill the fifo with memory stalled
      n = 0;
      @(negedge clk);
      w_v = 1'b1;
      w_d = 32'h0000_0D00;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (w_r !== 1'b1) break;
         n++;
         @(negedge clk);
         w_d = 32'h0000_0D00 + n;
      end
      chk("fifo_fill", n, FIFO_DEPTH);
      @(negedge clk);
      w_v = 1'b0;
      drain(FIFO_DEPTH);
      @(negedge clk);
      w_v = 1'b1;
      w_l = 1'b1;
      lat = 4'h3;
      w_d = 32'h0000_0D00 + FIFO_DEPTH;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (w_r === 1'b1) break;
      end
      @(negedge clk);
      w_v = 1'b0;
      w_l = 1'b0;
      // packet end starts the update while its last word still waits
      for (k = 0; k < 100 && wr_req !== 1'b1; k++) @(negedge clk);
      chk("upd_addr", wr_addr, 32'h0000_101C);
      chk("upd_flags", wr_data[31:30], 2'b11);
      chk("shortfall", short, 1'b1);
      for (k = 0; k < 100 && wr_req === 1'b1; k++) begin
         @(negedge clk);
         chk("no_fetch_before_upd", rd_req, 1'b0);
      end
      drain(FIFO_DEPTH + 1);
      for (k = 0; k < 100 && rd_req !== 1'b1; k++) @(negedge clk);
      chk("next_fetch", rd_addr, 32'h0000_1040);
      repeat (20) @(negedge clk);
      end_sim();
   end
endmodule // tb_top
